// File: rtl/ledfs_defs.vh
`ifndef LEDFS_DEFS_VH
`define LEDFS_DEFS_VH

// System clock rate in MHz; one timebase tick lasts TICK_US microseconds.
`define LEDFS_CLK_MHZ          250
`define LEDFS_TICK_US          1
`define LEDFS_TICK_CYC         (`LEDFS_CLK_MHZ * `LEDFS_TICK_US)

// Interval figures in microseconds, as printed.
`define LEDFS_OTP_BLANK_US     180
`define LEDFS_BO_BLANK_US      25000
`define LEDFS_GND_OPEN_US      200
`define LEDFS_AUX_SHORT_US     90000
`define LEDFS_RECOVER_US       4000000

// Interval lengths in timebase ticks, derived from the figures above.
`define LEDFS_OTP_BLANK_TK     (`LEDFS_OTP_BLANK_US / `LEDFS_TICK_US)
`define LEDFS_BO_BLANK_TK      (`LEDFS_BO_BLANK_US / `LEDFS_TICK_US)
`define LEDFS_GND_OPEN_TK      (`LEDFS_GND_OPEN_US / `LEDFS_TICK_US)
`define LEDFS_AUX_SHORT_TK     (`LEDFS_AUX_SHORT_US / `LEDFS_TICK_US)
`define LEDFS_RECOVER_TK       (`LEDFS_RECOVER_US / `LEDFS_TICK_US)

// Consecutive over-current periods that declare a winding or diode short.
`define LEDFS_WOD_PERIODS      3'h4

// Thermal-sense code thresholds (8-bit code of the thermal-sense voltage).
`define LEDFS_FB_END_CODE      8'h40
`define LEDFS_FB_SPAN_LOG2     5
`define LEDFS_OTP_TRIP_CODE    8'h30
`define LEDFS_OTP_REL_CODE     8'h40

// Fault cause bit positions in the sticky cause vector.
`define LEDFS_C_OTP            0
`define LEDFS_C_VCC_OVP        1
`define LEDFS_C_PROG_OVP       2
`define LEDFS_C_WOD            3
`define LEDFS_C_AUX            4
`define LEDFS_C_DIE_OT         5
`define LEDFS_C_CS_SHORT       6
`define LEDFS_C_GND_OPEN       7
`define LEDFS_C_BROWNOUT       8
`define LEDFS_NCAUSE           9

`endif

// File: rtl/ledfs_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for a group of independent slow levels.
module ledfs_sync #(
   parameter W = 1
) (
   input  wire         clk_sys_in,   // System clock.
   input  wire         resetn_in,    // Synchronous reset, active low.
   input  wire [W-1:0] async_in,     // Levels from outside the clock domain.
   output wire [W-1:0] sync_out      // Levels safe to use in the clock domain.
);
   reg [W-1:0] meta_ff;   // First stage, read only by the second stage.
   reg [W-1:0] sync_ff;   // Second stage, the only one logic may read.

   // Each bit is crossed on its own; no bit relies on another arriving together.
   always @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

// File: rtl/ledfs_timer.v
`timescale 1ns/1ps
// Persistence timer: counts ticks while run is high and clears when it drops.
module ledfs_timer #(
   parameter W     = 32,
   parameter LIMIT = 1
) (
   input  wire clk_sys_in,    // System clock.
   input  wire resetn_in,     // Synchronous reset, active low.
   input  wire tick_in,       // One-cycle timebase pulse.
   input  wire run_in,        // Condition that must persist.
   output wire expired_out    // High once the condition lasted LIMIT ticks.
);
   localparam [W-1:0] LIM = LIMIT;   // Limit at the counter width.

   reg [W-1:0] cnt_ff;   // Elapsed ticks of the current run.
   reg         exp_ff;   // Registered expiry flag.

   // The count saturates at the limit so a long run never wraps round.
   always @(posedge clk_sys_in) begin
      if (!resetn_in || !run_in) begin
         cnt_ff <= {W{1'b0}};
         exp_ff <= 1'b0;
      end else begin
         if (tick_in && cnt_ff != LIM) begin
            cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
         end
         exp_ff <= (cnt_ff == LIM);
      end
   end

   assign expired_out = exp_ff;
endmodule

// File: rtl/ledfs_top.v
// Function
// - Thermal foldback lowers reference down to half.
// - Foldback base is current before foldback starts.
// - Over-temperature trip faults; restart needs release level.
// - Latching variant also needs supply clear level.
// - Ignore over-temperature for 180 us after start.
// - Brown-out only after 25 ms continuous low line.
// - Resume when line released and supply started.
// - Brown-out recovery skips cycle-down, uses startup consumption.
// - Die over-temperature stops switching until it clears.
// - Check sense impedance at startup and max on-time.
// - Ground-open persisting 200 us stops drive pulses.
// - Every major fault interrupts drive pulse generation.
// - Latching fault holds until supply clear level.
// - Auto-recovery fault blocks 4 s, then restarts.
// - Variant parameter selects latching or auto-recovery policy.
// - No strong zero-cross pulse for 90 ms faults.
// - Four consecutive over-current periods fault as short.
`timescale 1ns/1ps
`include "ledfs_defs.vh"

module ledfs_top #(
   parameter LATCH_VARIANT  = 0,                     // 1 selects the latching policy.
   parameter REF_W          = 10,                    // Width of the current reference.
   parameter OTP_BLANK_TK   = `LEDFS_OTP_BLANK_TK,   // Over-temperature blanking, ticks.
   parameter BO_BLANK_TK    = `LEDFS_BO_BLANK_TK,    // Brown-out blanking, ticks.
   parameter GND_OPEN_TK    = `LEDFS_GND_OPEN_TK,    // Ground-open persistence, ticks.
   parameter AUX_SHORT_TK   = `LEDFS_AUX_SHORT_TK,   // Aux short timeout, ticks.
   parameter RECOVER_TK     = `LEDFS_RECOVER_TK,     // Auto-recovery delay, ticks.
   parameter TICK_CYC       = `LEDFS_TICK_CYC        // System cycles per timebase tick.
) (
   input  wire             clk_sys_in,               // System clock, 250 MHz.
   input  wire             resetn_in,                // Synchronous reset, active low.
   input  wire [7:0]       thermal_sense_code_in,    // Thermal-sense pin voltage code.
   input  wire             line_below_trip_in,       // Line sense below brownout_trip_level.
   input  wire             line_above_release_in,    // Line sense above brownout_release_level.
   input  wire             vcc_above_start_in,       // Supply above its start level.
   input  wire             vcc_below_clear_in,       // Supply below its clear level.
   input  wire             vcc_ovp_in,               // Supply overvoltage comparator.
   input  wire             programmable_overvoltage_in, // Thermal-sense pin overvoltage.
   input  wire             die_overtemp_shutdown_in, // Die over-temperature indication.
   input  wire             cs_impedance_ok_in,       // Sense pin impedance above minimum.
   input  wire             cs_diode_on_in,           // Sense pin protection diode conducts.
   input  wire             zero_cross_strong_in,     // Zero-cross pulse above short level.
   input  wire             cs_over_stop_in,          // Sense voltage above 150 % of limit.
   input  wire             period_end_in,            // Pulse: switching period ended.
   input  wire             max_on_end_in,            // Pulse: drive ended by max on-time.
   input  wire             dim_active_in,            // Step dimming engaged.
   input  wire [REF_W-1:0] dim_ref_in,               // Selected dimmed reference.
   input  wire [REF_W-1:0] full_ref_in,              // Full current reference.
   output wire             drive_enable_out,         // High while drive pulses are allowed.
   output wire             startup_mode_out,         // High for startup consumption mode.
   output wire             foldback_active_out,      // High while thermal foldback acts.
   output wire [REF_W-1:0] led_ref_out,              // Scaled current reference.
   output wire [`LEDFS_NCAUSE-1:0] fault_cause_out   // Sticky cause of last shutdown.
);

   // One-hot controller states.
   localparam [4:0] ST_START = 5'h01;   // Waiting for supply start, startup consumption.
   localparam [4:0] ST_RUN   = 5'h02;   // Switching allowed.
   localparam [4:0] ST_AUTO  = 5'h04;   // Auto-recovery delay running.
   localparam [4:0] ST_LATCH = 5'h08;   // Latched off until supply clear.
   localparam [4:0] ST_BROWN = 5'h10;   // Brown-out, fast restart pending.

   localparam [7:0] FB_END   = `LEDFS_FB_END_CODE;
   localparam [7:0] FB_START = `LEDFS_FB_END_CODE + (8'h01 << `LEDFS_FB_SPAN_LOG2);
   localparam [7:0] OTP_TRIP = `LEDFS_OTP_TRIP_CODE;
   localparam [7:0] OTP_REL  = `LEDFS_OTP_REL_CODE;
   localparam [15:0] TICK_LAST = TICK_CYC[15:0] - 16'h0001;

   // Synchronised copies of all analog comparator outputs.
   wire [7:0]  ts_code;        // Thermal-sense code.
   wire [11:0] cmp;            // Single-bit comparators.

   // Every comparator crosses two flip-flops before any logic looks at it.
   ledfs_sync #(.W(8)) u_sync_code (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .async_in   (thermal_sense_code_in),
      .sync_out   (ts_code)
   );
   ledfs_sync #(.W(12)) u_sync_cmp (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .async_in   ({line_below_trip_in, line_above_release_in, vcc_above_start_in,
                    vcc_below_clear_in, vcc_ovp_in, programmable_overvoltage_in,
                    die_overtemp_shutdown_in, cs_impedance_ok_in, cs_diode_on_in,
                    zero_cross_strong_in, cs_over_stop_in, 1'b0}),
      .sync_out   (cmp)
   );

   wire line_low   = cmp[11];   // Line below trip level.
   wire line_ok    = cmp[10];   // Line above release level.
   wire vcc_start  = cmp[9];    // Supply reached start level.
   wire vcc_clear  = cmp[8];    // Supply below clear level.
   wire vcc_ovp    = cmp[7];    // Supply overvoltage.
   wire prog_ovp   = cmp[6];    // Programmable overvoltage.
   wire die_ot     = cmp[5];    // Die over-temperature.
   wire cs_imp_ok  = cmp[4];    // Sense pin impedance acceptable.
   wire cs_diode   = cmp[3];    // Ground-open indicator.
   wire zc_strong  = cmp[2];    // Strong zero-cross pulse seen.
   wire cs_over    = cmp[1];    // Severe over-current seen.

   reg  [4:0]  state_ff;        // Controller state.
   reg  [4:0]  nxt_state;
   reg  [15:0] div_ff;          // Timebase divider.
   reg         tick_ff;         // One-cycle tick every TICK_CYC cycles.
   reg         otp_hold_ff;     // Over-temperature seen and not yet released.
   reg         nxt_otp_hold;
   reg         over_seen_ff;    // Over-current seen within this period.
   reg  [2:0]  wod_cnt_ff;      // Consecutive over-current periods.
   reg  [REF_W-1:0] base_ff;    // Reference frozen at foldback entry.
   reg  [REF_W-1:0] ref_ff;     // Registered output reference.
   reg         fb_ff;           // Registered foldback indication.
   reg         drv_ff;          // Registered drive enable.
   reg         stm_ff;          // Registered startup mode.
   reg  [`LEDFS_NCAUSE-1:0] cause_ff;   // Sticky fault cause.
   reg  [`LEDFS_NCAUSE-1:0] nxt_cause;
   reg  [`LEDFS_NCAUSE-1:0] fault_vec;  // Faults detected in this cycle.
   reg  [REF_W-1:0] nxt_ref;

   wire running = state_ff[1];
   wire blank_done;             // Over-temperature blanking elapsed.
   wire bo_expired;             // Brown-out blanking elapsed.
   wire gnd_expired;            // Ground-open persistence elapsed.
   wire aux_expired;            // Aux short timeout elapsed.
   wire rec_expired;            // Auto-recovery delay elapsed.

   // Divider that makes the single timebase tick for every interval.
   always @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         div_ff  <= 16'h0000;
         tick_ff <= 1'b0;
      end else if (div_ff == TICK_LAST) begin
         div_ff  <= 16'h0000;
         tick_ff <= 1'b1;
      end else begin
         div_ff  <= div_ff + 16'h0001;
         tick_ff <= 1'b0;
      end
   end

   // Blanking starts at each entry to RUN, so a filtered node can settle.
   ledfs_timer #(.W(32), .LIMIT(OTP_BLANK_TK)) u_blank (
      .clk_sys_in (clk_sys_in), .resetn_in (resetn_in), .tick_in (tick_ff),
      .run_in (running), .expired_out (blank_done));
   // Line must stay low without a single break for the whole blanking time.
   ledfs_timer #(.W(32), .LIMIT(BO_BLANK_TK)) u_bo (
      .clk_sys_in (clk_sys_in), .resetn_in (resetn_in), .tick_in (tick_ff),
      .run_in (running && line_low), .expired_out (bo_expired));
   ledfs_timer #(.W(32), .LIMIT(GND_OPEN_TK)) u_gnd (
      .clk_sys_in (clk_sys_in), .resetn_in (resetn_in), .tick_in (tick_ff),
      .run_in (running && cs_diode), .expired_out (gnd_expired));
   // Each strong zero-cross pulse restarts the aux short timer.
   ledfs_timer #(.W(32), .LIMIT(AUX_SHORT_TK)) u_aux (
      .clk_sys_in (clk_sys_in), .resetn_in (resetn_in), .tick_in (tick_ff),
      .run_in (running && !zc_strong), .expired_out (aux_expired));
   ledfs_timer #(.W(32), .LIMIT(RECOVER_TK)) u_rec (
      .clk_sys_in (clk_sys_in), .resetn_in (resetn_in), .tick_in (tick_ff),
      .run_in (state_ff[2]), .expired_out (rec_expired));

   // Over-current is remembered per period; a new event beats the period clear.
   always @(posedge clk_sys_in) begin
      if (!resetn_in || !running) begin
         over_seen_ff <= 1'b0;
         wod_cnt_ff   <= 3'h0;
      end else begin
         over_seen_ff <= cs_over || (over_seen_ff && !period_end_in);
         if (period_end_in) begin
            if (over_seen_ff || cs_over) begin
               if (wod_cnt_ff != `LEDFS_WOD_PERIODS) begin
                  wod_cnt_ff <= wod_cnt_ff + 3'h1;
               end
            end else begin
               wod_cnt_ff <= 3'h0;
            end
         end
      end
   end

   // Fault detection; the comparator for over-temperature is ignored while blanked.
   always @* begin
      fault_vec = {`LEDFS_NCAUSE{1'b0}};
      if (running) begin
         fault_vec[`LEDFS_C_OTP]      = blank_done && (ts_code < OTP_TRIP);
         fault_vec[`LEDFS_C_VCC_OVP]  = vcc_ovp;
         fault_vec[`LEDFS_C_PROG_OVP] = prog_ovp;
         fault_vec[`LEDFS_C_WOD]      = (wod_cnt_ff == `LEDFS_WOD_PERIODS);
         fault_vec[`LEDFS_C_AUX]      = aux_expired;
         fault_vec[`LEDFS_C_DIE_OT]   = die_ot;
         // Impedance is judged after each max on-time pulse; the start check is below.
         fault_vec[`LEDFS_C_CS_SHORT] = max_on_end_in && !cs_imp_ok;
         fault_vec[`LEDFS_C_GND_OPEN] = gnd_expired;
         fault_vec[`LEDFS_C_BROWNOUT] = bo_expired;
      end
   end

   // Faults that latch off in the latching variant; all others auto-recover, except a lone brown-out, which goes to BROWN.
   wire [`LEDFS_NCAUSE-1:0] latch_mask =
      (LATCH_VARIANT != 0) ? ({`LEDFS_NCAUSE{1'b0}} |
                               ({{(`LEDFS_NCAUSE-1){1'b0}}, 1'b1} << `LEDFS_C_OTP) |
                               ({{(`LEDFS_NCAUSE-1){1'b0}}, 1'b1} << `LEDFS_C_PROG_OVP) |
                               ({{(`LEDFS_NCAUSE-1){1'b0}}, 1'b1} << `LEDFS_C_WOD) |
                               ({{(`LEDFS_NCAUSE-1){1'b0}}, 1'b1} << `LEDFS_C_AUX))
                            : {`LEDFS_NCAUSE{1'b0}};
   wire brown_only = fault_vec[`LEDFS_C_BROWNOUT] &&
                     ((fault_vec & ~({{(`LEDFS_NCAUSE-1){1'b0}}, 1'b1}
                                     << `LEDFS_C_BROWNOUT)) == {`LEDFS_NCAUSE{1'b0}});
   wire any_fault  = |fault_vec;
   wire latch_hit  = |(fault_vec & latch_mask);

   // Restart is refused on over-temperature or a shorted sense pin at every start.
   wire may_start = vcc_start && !die_ot && !otp_hold_ff && cs_imp_ok;

   // Main controller state machine.
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_START: begin
            if (may_start) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (latch_hit) begin
               nxt_state = ST_LATCH;
            end else if (brown_only) begin
               nxt_state = ST_BROWN;
            end else if (any_fault) begin
               nxt_state = ST_AUTO;
            end
         end
         ST_AUTO: begin
            // After the delay the ordinary start condition still applies.
            if (rec_expired) begin
               nxt_state = ST_START;
            end
         end
         ST_LATCH: begin
            if (vcc_clear) begin
               nxt_state = ST_START;
            end
         end
         ST_BROWN: begin
            // No supply cycle-down is needed; startup mode recharges the supply.
            if (line_ok && may_start) begin
               nxt_state = ST_RUN;
            end
         end
         default: begin
            nxt_state = ST_START;
         end
      endcase
   end

   // Over-temperature hold clears only above the release level; a trip wins.
   always @* begin
      nxt_otp_hold = otp_hold_ff;
      if (ts_code > OTP_REL) begin
         nxt_otp_hold = 1'b0;
      end
      if (fault_vec[`LEDFS_C_OTP]) begin
         nxt_otp_hold = 1'b1;
      end
   end

   // Cause clears on restart into RUN; a fault in the same cycle is kept.
   always @* begin
      nxt_cause = cause_ff;
      if (!running && nxt_state == ST_RUN) begin
         nxt_cause = {`LEDFS_NCAUSE{1'b0}};
      end
      if (any_fault) begin
         nxt_cause = fault_vec;
      end
   end

   // Foldback scaling: linear from full base at start down to half at end.
   wire [REF_W-1:0] pre_ref = dim_active_in ? dim_ref_in : full_ref_in;
   wire             in_fb   = (ts_code < FB_START);
   wire [REF_W-1:0] half    = {1'b0, base_ff[REF_W-1:1]};
   wire [7:0]       depth   = ts_code - FB_END;
   wire [REF_W+7:0] prod    = half * depth;
   wire [REF_W+7:0] scaled  = prod >> `LEDFS_FB_SPAN_LOG2;

   always @* begin
      if (!in_fb) begin
         nxt_ref = pre_ref;
      end else if (ts_code <= FB_END) begin
         nxt_ref = half;
      end else begin
         nxt_ref = half + scaled[REF_W-1:0];
      end
   end

   // Controller state, hold, cause, base and all registered outputs.
   always @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         state_ff    <= ST_START;
         otp_hold_ff <= 1'b0;
         cause_ff    <= {`LEDFS_NCAUSE{1'b0}};
         base_ff     <= {REF_W{1'b0}};
         ref_ff      <= {REF_W{1'b0}};
         fb_ff       <= 1'b0;
         drv_ff      <= 1'b0;
         stm_ff      <= 1'b1;
      end else begin
         state_ff    <= nxt_state;
         otp_hold_ff <= nxt_otp_hold;
         cause_ff    <= nxt_cause;
         // The base tracks the current in force until foldback begins.
         if (!in_fb) begin
            base_ff <= pre_ref;
         end
         ref_ff      <= nxt_ref;
         fb_ff       <= in_fb;
         // Drive is dropped in the same edge that a fault is seen.
         drv_ff      <= (nxt_state == ST_RUN) && !(running && any_fault);
         stm_ff      <= (nxt_state == ST_START) || (nxt_state == ST_BROWN);
      end
   end

   assign drive_enable_out    = drv_ff;
   assign startup_mode_out    = stm_ff;
   assign foldback_active_out = fb_ff;
   assign led_ref_out         = ref_ff;
   assign fault_cause_out     = cause_ff;
endmodule

// File: dv/ledfs_props.sv
`timescale 1ns/1ps
// Watches the supervisor pins; small counters measure how long each level has lasted.
module ledfs_props #(
   parameter OTP_BLANK_TK = 1, BO_BLANK_TK = 1, GND_OPEN_TK = 1, RECOVER_TK = 1,
   parameter TICK_CYC     = 1
) (
   input wire       clk_sys_in, resetn_in, line_below_trip_in, vcc_above_start_in,
   input wire       vcc_ovp_in, die_overtemp_shutdown_in, cs_diode_on_in, dim_active_in,
   input wire       drive_enable_out, startup_mode_out, foldback_active_out,
   input wire [7:0] thermal_sense_code_in,
   input wire [9:0] full_ref_in, led_ref_out,
   input wire [8:0] fault_cause_out
);
   int on_c = 0, off_c = 0, lb_c = 0, go_c = 0;  // Cycles each level has lasted.
   // Limits keep one tick of slack, because the tick phase is free against the inputs.
   always @(posedge clk_sys_in) begin
      on_c  <= drive_enable_out ? on_c + 1 : 0;
      off_c <= drive_enable_out ? 0 : off_c + 1;
      lb_c  <= line_below_trip_in ? lb_c + 1 : 0;
      go_c  <= cs_diode_on_in ? go_c + 1 : 0;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   a_ovp_stops_drive: assert property (
      drive_enable_out && vcc_ovp_in |-> ##[1:5] !drive_enable_out) else $error("drive kept on");
   a_die_hot_off: assert property (
      die_overtemp_shutdown_in [*5] |-> !drive_enable_out) else $error("drive on while die hot");
   a_cause_on_stop: assert property (
      $fell(drive_enable_out) |-> fault_cause_out != 9'h000) else $error("stop with no cause");
   a_cause_clr_run: assert property (
      $rose(drive_enable_out) |-> fault_cause_out == 9'h000) else $error("cause kept on restart");
   a_start_needs_vcc: assert property (
      $rose(drive_enable_out) |-> $past(vcc_above_start_in, 3)) else $error("start without supply");
   a_hot_folds: assert property (
      (thermal_sense_code_in < 8'h40) [*6] |-> foldback_active_out) else $error("no foldback");
   a_cool_full_ref: assert property (
      (thermal_sense_code_in >= 8'h60 && !dim_active_in && drive_enable_out && $stable(full_ref_in))
      [*6] |-> led_ref_out == full_ref_in) else $error("reference not full when cool");
   a_brown_blank: assert property (
      $fell(drive_enable_out) && fault_cause_out[8] |-> lb_c >= (BO_BLANK_TK - 1) * TICK_CYC)
      else $error("brownout declared too early");
   a_brown_startup: assert property (
      $fell(drive_enable_out) && fault_cause_out[8] |-> startup_mode_out) else $error("no startup");
   a_gnd_blank: assert property (
      $fell(drive_enable_out) && fault_cause_out[7] |-> go_c >= (GND_OPEN_TK - 1) * TICK_CYC)
      else $error("ground open declared too early");
   a_recover_wait: assert property (
      $rose(drive_enable_out) && $past(fault_cause_out[1]) |-> off_c >= (RECOVER_TK - 1) * TICK_CYC)
      else $error("auto recovery too early");
   a_otp_blank: assert property (
      $fell(drive_enable_out) && fault_cause_out[0] |-> on_c >= (OTP_BLANK_TK - 1) * TICK_CYC)
      else $error("over temperature judged during blanking");
   c_brownout: cover property ($fell(drive_enable_out) && fault_cause_out[8]);
   c_otp_trip: cover property ($fell(drive_enable_out) && fault_cause_out[0]);
   c_recover: cover property ($rose(drive_enable_out) && $past(fault_cause_out[1]));
endmodule
bind ledfs_top ledfs_props #(.OTP_BLANK_TK(OTP_BLANK_TK), .BO_BLANK_TK(BO_BLANK_TK),
   .GND_OPEN_TK(GND_OPEN_TK), .RECOVER_TK(RECOVER_TK), .TICK_CYC(TICK_CYC)) u_props (
   .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .line_below_trip_in(line_below_trip_in),
   .vcc_above_start_in(vcc_above_start_in), .vcc_ovp_in(vcc_ovp_in),
   .die_overtemp_shutdown_in(die_overtemp_shutdown_in), .cs_diode_on_in(cs_diode_on_in),
   .dim_active_in(dim_active_in), .drive_enable_out(drive_enable_out),
   .startup_mode_out(startup_mode_out), .foldback_active_out(foldback_active_out),
   .thermal_sense_code_in(thermal_sense_code_in), .full_ref_in(full_ref_in),
   .led_ref_out(led_ref_out), .fault_cause_out(fault_cause_out));

// File: dv/ledfs_supply.sv
`timescale 1ns/1ps
// Supply model: the rail sags when the block drops to startup current, then recharges.
module ledfs_supply (
   input  wire clk_sys_in, startup_in, slow_in,
   output reg  vcc_up_out = 1'b0,
   output wire vcc_clear_out
);
   int chg = 0;  // Cycles spent charging; a slow supply needs far more of them.
   always @(posedge clk_sys_in) begin
      chg        <= startup_in ? chg + 1 : 0;
      vcc_up_out <= !startup_in || chg >= (slow_in ? 60 : 3);
   end
   assign vcc_clear_out = startup_in && chg < 2;  // Briefly under the clear level after a sag.
endmodule

// File: dv/ledfs_top_test.sv
`timescale 1ns/1ps
module ledfs_top_test;
   localparam int TC = 4, OB = 5, BB = 8, GB = 6, AB = 20, RB = 10;
   localparam int BITS[8] = '{1, 2, 5, 0, 6, 7, 4, 3};  // Cause bit of each injected fault.
   localparam logic [7:0] CODES[8] = '{8'h80, 8'h5f, 8'h50, 8'h41, 8'h40, 8'h30, 8'h60, 8'h48};
   reg clk_sys_in = 0, resetn_in = 0, lb = 0, la = 1, vovp = 0, pov = 0, die = 0, impok = 1;
   reg diode = 0, zc = 0, csov = 0, pe = 0, moe = 0, dim = 0, slow = 0;
   reg [7:0] code = 8'h80, f = 8'h00;  // f injects one fault at a time.
   reg [9:0] dref = 10'h000, fref = 10'h000;
   wire drv, stm, fba, vup, vclr;
   wire [9:0] lref;
   wire [8:0] cause;
   int n_errors = 0, cmp_count = 0, cyc = 0, i, k;
   ledfs_top #(.OTP_BLANK_TK(OB), .BO_BLANK_TK(BB), .GND_OPEN_TK(GB), .AUX_SHORT_TK(AB),
      .RECOVER_TK(RB), .TICK_CYC(TC)) dut_u (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .thermal_sense_code_in(code), .line_below_trip_in(lb), .line_above_release_in(la),
      .vcc_above_start_in(vup), .vcc_below_clear_in(vclr), .vcc_ovp_in(vovp),
      .programmable_overvoltage_in(pov), .die_overtemp_shutdown_in(die),
      .cs_impedance_ok_in(impok), .cs_diode_on_in(diode), .zero_cross_strong_in(zc),
      .cs_over_stop_in(csov), .period_end_in(pe), .max_on_end_in(moe), .dim_active_in(dim),
      .dim_ref_in(dref), .full_ref_in(fref), .drive_enable_out(drv), .startup_mode_out(stm),
      .foldback_active_out(fba), .led_ref_out(lref), .fault_cause_out(cause));
   ledfs_supply sup_u (.clk_sys_in(clk_sys_in), .startup_in(stm), .slow_in(slow),
      .vcc_up_out(vup), .vcc_clear_out(vclr));
   always #2 clk_sys_in = ~clk_sys_in;
   // Background switching activity; zero-cross pulses last four cycles so the sync sees them.
   always @(posedge clk_sys_in) begin
      cyc   <= cyc + 1;
      pe    <= ($urandom % 4) == 0;
      moe   <= ($urandom % 16) == 0;
      zc    <= !f[6] && cyc[2];
      vovp  <= f[0];
      pov   <= f[1];
      die   <= f[2];
      impok <= !f[4];
      diode <= f[5];
      csov  <= f[7];
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   task chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Waits on falling edges so registered outputs have settled.
   task wait_drv(input logic lvl, input int lim);
      k = 0;
      @(negedge clk_sys_in);
      while (drv !== lvl && k < lim) begin
         @(negedge clk_sys_in);
         k++;
      end
   endtask
   task stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Half the reference at the foldback end, a linear blend across the 32-code span.
   function automatic logic [9:0] exp_ref(input logic [9:0] b, input logic [7:0] c);
      logic [9:0] h;
      int m;
      h = b >> 1;
      m = h * (c - 8'h40);
      if (c >= 8'h60) return b;
      if (c <= 8'h40) return h;
      return h + 10'(m >> 5);
   endfunction
   initial begin
      i = $urandom(32'hbd72_2a54);
      repeat (3) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      wait_drv(1'b1, 200);
      chk("drive", {9'h000, drv}, 10'h001);
      chk("cause", {1'b0, cause}, 10'h000);
      $display("startup test done");
      for (i = 0; i < 8; i++) begin
         @(posedge clk_sys_in);
         code <= 8'h80;
         dim  <= i[0];
         dref <= 10'($urandom);
         fref <= 10'($urandom);
         repeat (8) @(posedge clk_sys_in);
         code <= CODES[i];
         repeat (8) @(posedge clk_sys_in);
         @(negedge clk_sys_in);
         chk("led_ref", lref, exp_ref(i[0] ? dref : fref, CODES[i]));
         chk("foldback", {9'h000, fba}, {9'h000, CODES[i] < 8'h60});
      end
      $display("foldback test done");
      for (i = 0; i < 8; i++) begin
         @(posedge clk_sys_in);
         f    <= 8'h01 << i;
         slow <= i[0];
         code <= (i == 3) ? 8'h20 : 8'h80;
         wait_drv(1'b0, 300);
         chk("cause", {1'b0, cause}, 10'(1 << BITS[i]));
         @(posedge clk_sys_in);
         f    <= 8'h00;
         code <= 8'h80;
         wait_drv(1'b1, 400);
         chk("drive", {9'h000, drv}, 10'h001);
      end
      $display("fault test done");
      @(posedge clk_sys_in);
      {lb, la} <= 2'b10;
      repeat (20) @(posedge clk_sys_in);
      {lb, la} <= 2'b01;
      @(negedge clk_sys_in);
      chk("drive", {9'h000, drv}, 10'h001);
      @(posedge clk_sys_in);
      {lb, la} <= 2'b10;
      wait_drv(1'b0, 100);
      chk("cause", {1'b0, cause}, 10'h100);
      chk("startup", {9'h000, stm}, 10'h001);
      @(posedge clk_sys_in);
      {lb, la} <= 2'b01;
      wait_drv(1'b1, 200);
      chk("cause", {1'b0, cause}, 10'h000);
      $display("brownout test done");
      stop_test();
   end
endmodule
